// ---- rtl/analog_route_control_regs.sv ----
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "arc_defines.svh"
module analog_route_control_regs
    import arc_pkg::*;
(
    // Clocking
    input  wire logic      mclk,
    input  wire logic      reset,
    input  wire logic      clkEn,
    // Power-down pin, active low
    input  wire logic      chip_powerdown_pin_n,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire arc_byte_t regWrData,
    input  wire logic      regWrStb,
    input  wire logic      regRdStb,
    output arc_byte_t      regRdData,
    // Headphone controls
    output logic [7:0]     hpRouteEn,
    output logic [2:0]     pairAvgToPhones,
    output logic           diffInToPhonesEn,
    output logic [4:0]     hp_attenuation_level,
    output logic           hp_silence,
    output logic           hp_weak_pulldown_sel,
    // Line output controls
    output logic [7:0]     lineRouteEn,
    output logic [2:0]     pairAvgToLine,
    output logic           diff_in_to_line_en,
    // Mono output controls
    output logic [7:0]     monoRouteEn,
    output logic           diffInToSingleOutEn,
    output logic [3:0]     mono_attenuation_level,
    output logic           mono_silence,
    output logic           mono_dac_gain_sel,
    output logic           mono_stage_power_on
);
    function automatic arc_reg_sel_t decode(input logic [7:0] addr);
        case (addr)
            `ARC_ADDR_HP_ROUTE:   decode = ARC_HP_ROUTE;
            `ARC_ADDR_HP_LEVEL:   decode = ARC_HP_LEVEL;
            `ARC_ADDR_LINE_ROUTE: decode = ARC_LINE_ROUTE;
            `ARC_ADDR_AVG_MIX:    decode = ARC_AVG_MIX;
            `ARC_ADDR_DIFF_SEL:   decode = ARC_DIFF_SEL;
            `ARC_ADDR_MONO_ROUTE: decode = ARC_MONO_ROUTE;
            `ARC_ADDR_MONO_LEVEL: decode = ARC_MONO_LEVEL;
            default:              decode = ARC_NONE;
        endcase
    endfunction : decode

    arc_reg_sel_t wrSel;
    arc_reg_sel_t rdSel;
    logic         powerDown;
    arc_byte_t    hpRoute;
    arc_byte_t    hpLevel;
    arc_byte_t    lineRoute;
    arc_byte_t    avgMix;
    arc_byte_t    diffSel;
    arc_byte_t    monoRoute;
    arc_byte_t    monoLevel;

    assign wrSel     = regWrStb ? decode(regAddr) : ARC_NONE;
    assign rdSel     = decode(regAddr);
    assign powerDown = ~chip_powerdown_pin_n;

    arc_reg_byte #(.RST_VAL(`ARC_RST_HP_ROUTE), .WR_MASK(8'hff)) uHpRoute (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .powerDown(powerDown),
        .wrEn(wrSel == ARC_HP_ROUTE), .wrData(regWrData), .value(hpRoute)
    );
    arc_reg_byte #(.RST_VAL(`ARC_RST_HP_LEVEL), .WR_MASK(`ARC_MASK_HP_LEVEL)) uHpLevel (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .powerDown(powerDown),
        .wrEn(wrSel == ARC_HP_LEVEL), .wrData(regWrData), .value(hpLevel)
    );
    arc_reg_byte #(.RST_VAL(`ARC_RST_LINE_ROUTE), .WR_MASK(8'hff)) uLineRoute (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .powerDown(powerDown),
        .wrEn(wrSel == ARC_LINE_ROUTE), .wrData(regWrData), .value(lineRoute)
    );
    arc_reg_byte #(.RST_VAL(`ARC_RST_AVG_MIX), .WR_MASK(`ARC_MASK_AVG_MIX)) uAvgMix (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .powerDown(powerDown),
        .wrEn(wrSel == ARC_AVG_MIX), .wrData(regWrData), .value(avgMix)
    );
    arc_reg_byte #(.RST_VAL(`ARC_RST_DIFF_SEL), .WR_MASK(`ARC_MASK_DIFF_SEL)) uDiffSel (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .powerDown(powerDown),
        .wrEn(wrSel == ARC_DIFF_SEL), .wrData(regWrData), .value(diffSel)
    );
    arc_reg_byte #(.RST_VAL(`ARC_RST_MONO_ROUTE), .WR_MASK(8'hff)) uMonoRoute (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .powerDown(powerDown),
        .wrEn(wrSel == ARC_MONO_ROUTE), .wrData(regWrData), .value(monoRoute)
    );
    arc_reg_byte #(.RST_VAL(`ARC_RST_MONO_LEVEL), .WR_MASK(`ARC_MASK_MONO_LEVEL)) uMonoLevel (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .powerDown(powerDown),
        .wrEn(wrSel == ARC_MONO_LEVEL), .wrData(regWrData), .value(monoLevel)
    );

    // Read data and derived control outputs, all registered.
    arc_byte_t  rdData_r,       rdData_nxt;
    logic [7:0] hpRoute_r,      hpRoute_nxt;
    logic [2:0] avgPh_r,        avgPh_nxt;
    logic       diffPh_r,       diffPh_nxt;
    logic [4:0] hpAtt_r,        hpAtt_nxt;
    logic       hpMute_r,       hpMute_nxt;
    logic       hpPull_r,       hpPull_nxt;
    logic [7:0] lineRoute_r,    lineRoute_nxt;
    logic [2:0] avgLine_r,      avgLine_nxt;
    logic       diffLine_r,     diffLine_nxt;
    logic [7:0] monoRoute_r,    monoRoute_nxt;
    logic       diffMono_r,     diffMono_nxt;
    logic [3:0] monoAtt_r,      monoAtt_nxt;
    logic       monoMute_r,     monoMute_nxt;
    logic       monoGain_r,     monoGain_nxt;
    logic       monoPwr_r,      monoPwr_nxt;

    always_comb begin
        rdData_nxt = 8'h00;
        if (regRdStb) begin
            case (rdSel)
                ARC_HP_ROUTE:   rdData_nxt = hpRoute;
                ARC_HP_LEVEL:   rdData_nxt = hpLevel;
                ARC_LINE_ROUTE: rdData_nxt = lineRoute;
                ARC_AVG_MIX:    rdData_nxt = avgMix;
                ARC_DIFF_SEL:   rdData_nxt = diffSel;
                ARC_MONO_ROUTE: rdData_nxt = monoRoute;
                ARC_MONO_LEVEL: rdData_nxt = monoLevel;
                default:        rdData_nxt = 8'h00;
            endcase
        end
        hpRoute_nxt   = hpRoute;
        avgPh_nxt     = {avgMix[4], avgMix[2], avgMix[0]};
        avgLine_nxt   = {avgMix[5], avgMix[3], avgMix[1]};
        diffLine_nxt  = diffSel[`ARC_DIFF_EN_BIT];
        diffPh_nxt    = diffSel[`ARC_DIFF_EN_BIT] & diffSel[`ARC_DIFF_HP_BIT];
        diffMono_nxt  = diffSel[`ARC_DIFF_EN_BIT] & diffSel[`ARC_DIFF_MONO_BIT];
        hpMute_nxt    = hpLevel[`ARC_HP_MUTE_BIT];
        hpAtt_nxt     = hpLevel[`ARC_HP_MUTE_BIT] ? 5'h00 : hpLevel[4:0];
        hpPull_nxt    = hpLevel[`ARC_HP_PULL_BIT];
        lineRoute_nxt = lineRoute;
        monoRoute_nxt = monoRoute;
        monoMute_nxt  = monoLevel[`ARC_MONO_MUTE_BIT];
        monoAtt_nxt   = monoLevel[`ARC_MONO_MUTE_BIT] ? 4'h0 : monoLevel[3:0];
        monoGain_nxt  = monoLevel[`ARC_MONO_GAIN_BIT];
        monoPwr_nxt   = monoLevel[`ARC_MONO_PWR_BIT];
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdData_r    <= 8'h00;
            hpRoute_r   <= 8'h00;
            avgPh_r     <= 3'h0;
            diffPh_r    <= 1'b0;
            hpAtt_r     <= 5'h00;
            hpMute_r    <= 1'b0;
            hpPull_r    <= 1'b0;
            lineRoute_r <= 8'h00;
            avgLine_r   <= 3'h0;
            diffLine_r  <= 1'b0;
            monoRoute_r <= 8'h00;
            diffMono_r  <= 1'b0;
            monoAtt_r   <= 4'h0;
            monoMute_r  <= 1'b1;
            monoGain_r  <= 1'b0;
            monoPwr_r   <= 1'b0;
        end else if (clkEn) begin
            rdData_r    <= rdData_nxt;
            hpRoute_r   <= hpRoute_nxt;
            avgPh_r     <= avgPh_nxt;
            diffPh_r    <= diffPh_nxt;
            hpAtt_r     <= hpAtt_nxt;
            hpMute_r    <= hpMute_nxt;
            hpPull_r    <= hpPull_nxt;
            lineRoute_r <= lineRoute_nxt;
            avgLine_r   <= avgLine_nxt;
            diffLine_r  <= diffLine_nxt;
            monoRoute_r <= monoRoute_nxt;
            diffMono_r  <= diffMono_nxt;
            monoAtt_r   <= monoAtt_nxt;
            monoMute_r  <= monoMute_nxt;
            monoGain_r  <= monoGain_nxt;
            monoPwr_r   <= monoPwr_nxt;
        end
    end

    assign regRdData              = rdData_r;
    assign hpRouteEn              = hpRoute_r;
    assign pairAvgToPhones        = avgPh_r;
    assign diffInToPhonesEn       = diffPh_r;
    assign hp_attenuation_level   = hpAtt_r;
    assign hp_silence             = hpMute_r;
    assign hp_weak_pulldown_sel   = hpPull_r;
    assign lineRouteEn            = lineRoute_r;
    assign pairAvgToLine          = avgLine_r;
    assign diff_in_to_line_en     = diffLine_r;
    assign monoRouteEn            = monoRoute_r;
    assign diffInToSingleOutEn    = diffMono_r;
    assign mono_attenuation_level = monoAtt_r;
    assign mono_silence           = monoMute_r;
    assign mono_dac_gain_sel      = monoGain_r;
    assign mono_stage_power_on    = monoPwr_r;
endmodule : analog_route_control_regs

// ---- rtl/arc_defines.svh ----
// Functional notes
// - Each headphone route bit, reset 0, joins one input channel to one headphone side when 1.
// - Headphone attenuation is five bits in 4 to 0, resets to 0 dB and acts only while unmuted.
// - The headphone mute bit, reset 0, silences the headphones and overrides the attenuation.
// - The headphone pull-down select, reset 0, shorts to ground, and 1 picks the weak pull-down.
// - Each line route bit, reset 0, joins one input channel to a line output when 1.
// - Mix bits 0, 2, 4 add pair averages 1 to 3 to the headphones, and bits 7 and 6 read 0.
// - Mix bits 1, 3, 5 add pair averages 1 to 3 to the line outputs, and they reset to 0.
// - Differential bit 0 makes pair 1 one differential input and routes it to the line outputs.
// - Diff bits 1 and 2 act only while bit 0 is set, reset to 0, and bits 7 to 3 read 0.
// - Each mono route bit, reset 0, adds a converter or input channel to the mono output.
// - Mono level has a four-bit attenuation and a mute bit in bit 4 that resets to 1.
// - The mono attenuation acts only while the mono mute bit is clear.
// - Mono level bit 5, reset 0, sets the converter-to-mono gain to 0 dB at 0 and +6 dB at 1.
// - Mono level bit 6 powers the mono stage, and at 0, the reset value, its pin floats.
// - While the power-down pin is low every field returns to its reset value.
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH
`define ARC_ADDR_HP_ROUTE    8'h0d
`define ARC_ADDR_HP_LEVEL    8'h0e
`define ARC_ADDR_LINE_ROUTE  8'h0f
`define ARC_ADDR_AVG_MIX     8'h10
`define ARC_ADDR_DIFF_SEL    8'h11
`define ARC_ADDR_MONO_ROUTE  8'h12
`define ARC_ADDR_MONO_LEVEL  8'h13
`define ARC_RST_HP_ROUTE     8'h00
`define ARC_RST_HP_LEVEL     8'h00
`define ARC_RST_LINE_ROUTE   8'h00
`define ARC_RST_AVG_MIX      8'h00
`define ARC_RST_DIFF_SEL     8'h00
`define ARC_RST_MONO_ROUTE   8'h00
`define ARC_RST_MONO_LEVEL   8'h10
`define ARC_MASK_HP_LEVEL    8'h7f
`define ARC_MASK_AVG_MIX     8'h3f
`define ARC_MASK_DIFF_SEL    8'h07
`define ARC_MASK_MONO_LEVEL  8'h7f
`define ARC_HP_MUTE_BIT      5
`define ARC_HP_PULL_BIT      6
`define ARC_MONO_MUTE_BIT    4
`define ARC_MONO_GAIN_BIT    5
`define ARC_MONO_PWR_BIT     6
`define ARC_DIFF_EN_BIT      0
`define ARC_DIFF_HP_BIT      1
`define ARC_DIFF_MONO_BIT    2
`endif

// ---- rtl/arc_pkg.sv ----
package arc_pkg;
    typedef logic [7:0] arc_byte_t;
    typedef enum logic [2:0] {
        ARC_HP_ROUTE,
        ARC_HP_LEVEL,
        ARC_LINE_ROUTE,
        ARC_AVG_MIX,
        ARC_DIFF_SEL,
        ARC_MONO_ROUTE,
        ARC_MONO_LEVEL,
        ARC_NONE
    } arc_reg_sel_t;
endpackage : arc_pkg

// ---- rtl/arc_reg_byte.sv ----
`timescale 1ns/10ps
// One control byte with a write mask; masked bits always hold 0.
module arc_reg_byte
    import arc_pkg::*;
#(
    parameter arc_byte_t RST_VAL = 8'h00,
    parameter arc_byte_t WR_MASK = 8'hff
) (
    // Clocking
    input  wire logic      mclk,
    input  wire logic      reset,
    input  wire logic      clkEn,
    input  wire logic      powerDown,
    // Write port
    input  wire logic      wrEn,
    input  wire arc_byte_t wrData,
    // Stored value
    output arc_byte_t      value
);
    arc_byte_t value_r;
    arc_byte_t value_nxt;

    always_comb begin
        value_nxt = value_r;
        if (powerDown) begin
            value_nxt = RST_VAL;
        end else if (wrEn) begin
            value_nxt = wrData & WR_MASK;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            value_r <= RST_VAL;
        end else if (clkEn) begin
            value_r <= value_nxt;
        end
    end

    assign value = value_r;
endmodule : arc_reg_byte

// ---- sim/arc_route_chk.sv ----
`timescale 1ns/10ps
module arc_route_chk
    import arc_pkg::*;
(
    // Clocking and register port
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       clkEn,
    input wire logic       chip_powerdown_pin_n,
    input wire logic [7:0] regAddr,
    input wire arc_byte_t  regWrData,
    input wire logic       regWrStb,
    input wire logic       regRdStb,
    input wire arc_byte_t  regRdData,
    // Controls
    input wire logic [7:0] hpRouteEn,
    input wire logic [2:0] pairAvgToPhones,
    input wire logic [2:0] pairAvgToLine,
    input wire logic [7:0] monoRouteEn,
    input wire logic [4:0] hp_attenuation_level,
    input wire logic       hp_silence,
    input wire logic       hp_weak_pulldown_sel,
    input wire logic [7:0] lineRouteEn,
    input wire logic       diff_in_to_line_en,
    input wire logic       diffInToPhonesEn,
    input wire logic       diffInToSingleOutEn,
    input wire logic [3:0] mono_attenuation_level,
    input wire logic       mono_silence,
    input wire logic       mono_dac_gain_sel,
    input wire logic       mono_stage_power_on
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // A write that is taken and then copied to the outputs at the next edge.
    sequence wrAt(logic [7:0] a);
        clkEn && chip_powerdown_pin_n && regWrStb && regAddr == a ##1 clkEn && chip_powerdown_pin_n;
    endsequence
    sequence rdAt(logic [7:0] a);
        clkEn && regRdStb && regAddr == a;
    endsequence
    sequence pdHold;
        (clkEn && !chip_powerdown_pin_n) [*2];
    endsequence
    chk_hp_mute_gate: assert property (hp_silence |-> hp_attenuation_level == 5'h00)
        else $error("headphone level not zero while muted");
    chk_mono_mute_gate: assert property (mono_silence |-> mono_attenuation_level == 4'h0)
        else $error("mono level not zero while muted");
    chk_diff_gate: assert property (!diff_in_to_line_en |->
        !diffInToPhonesEn && !diffInToSingleOutEn)
        else $error("differential route active while disabled");
    chk_pd_clears: assert property (pdHold |=>
        hpRouteEn == 8'h00 && lineRouteEn == 8'h00 && monoRouteEn == 8'h00
        && mono_silence && !mono_stage_power_on)
        else $error("power-down did not clear outputs");
    chk_hp_route_out: assert property (wrAt(8'h0d) |=>
        hpRouteEn == $past(regWrData, 2))
        else $error("headphone route output wrong");
    chk_line_route_out: assert property (wrAt(8'h0f) |=>
        lineRouteEn == $past(regWrData, 2))
        else $error("line route output wrong");
    chk_mono_route_out: assert property (wrAt(8'h12) |=>
        monoRouteEn == $past(regWrData, 2))
        else $error("mono route output wrong");
    chk_avg_mix_out: assert property (wrAt(8'h10) |=>
        {pairAvgToLine, pairAvgToPhones} == $past({regWrData[5], regWrData[3], regWrData[1],
        regWrData[4], regWrData[2], regWrData[0]}, 2))
        else $error("pair average outputs wrong");
    chk_diff_route_out: assert property (wrAt(8'h11) |=>
        {diffInToSingleOutEn, diffInToPhonesEn, diff_in_to_line_en}
        == $past(regWrData[0] ? regWrData[2:0] : 3'h0, 2))
        else $error("differential route outputs wrong");
    chk_hp_level_out: assert property (wrAt(8'h0e) |=>
        {hp_weak_pulldown_sel, hp_silence} == $past(regWrData[6:5], 2))
        else $error("headphone level controls wrong");
    chk_hp_att_out: assert property (wrAt(8'h0e) |=>
        hp_silence || hp_attenuation_level == $past(regWrData[4:0], 2))
        else $error("headphone attenuation wrong");
    chk_mono_level_out: assert property (wrAt(8'h13) |=>
        {mono_stage_power_on, mono_dac_gain_sel} == $past(regWrData[6:5], 2))
        else $error("mono gain or power wrong");
    chk_mono_att_out: assert property (wrAt(8'h13) |=>
        mono_silence || mono_attenuation_level == $past(regWrData[3:0], 2))
        else $error("mono attenuation wrong");
    chk_mix_reserved: assert property (rdAt(8'h10) |=> regRdData[7:6] == 2'h0)
        else $error("mix reserved bits not zero");
    chk_diff_reserved: assert property (rdAt(8'h11) |=> regRdData[7:3] == 5'h00)
        else $error("differential reserved bits not zero");
    chk_unmapped_rd: assert property (
        clkEn && regRdStb && (regAddr < 8'h0d || regAddr > 8'h13) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
endmodule : arc_route_chk

bind analog_route_control_regs arc_route_chk u_chk (.mclk(mclk), .reset(reset), .clkEn(clkEn),
    .chip_powerdown_pin_n(chip_powerdown_pin_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .hpRouteEn(hpRouteEn),
    .hp_attenuation_level(hp_attenuation_level), .hp_silence(hp_silence),
    .hp_weak_pulldown_sel(hp_weak_pulldown_sel), .lineRouteEn(lineRouteEn),
    .diff_in_to_line_en(diff_in_to_line_en), .diffInToPhonesEn(diffInToPhonesEn),
    .diffInToSingleOutEn(diffInToSingleOutEn), .mono_attenuation_level(mono_attenuation_level),
    .mono_silence(mono_silence), .mono_dac_gain_sel(mono_dac_gain_sel),
    .mono_stage_power_on(mono_stage_power_on), .pairAvgToPhones(pairAvgToPhones),
    .pairAvgToLine(pairAvgToLine), .monoRouteEn(monoRouteEn));

// ---- sim/analog_route_control_regs_tb.sv ----
`timescale 1ns/10ps
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module analog_route_control_regs_tb;
    import arc_pkg::*;
    localparam arc_byte_t RST [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10};
    localparam arc_byte_t MSK [7] = '{8'hff, 8'h7f, 8'hff, 8'h3f, 8'h07, 8'hff, 8'h7f};
    logic       mclk;
    logic       reset;
    logic       clkEn;
    logic       chip_powerdown_pin_n;
    logic [7:0] regAddr;
    arc_byte_t  regWrData;
    logic       regWrStb;
    logic       regRdStb;
    arc_byte_t  regRdData;
    arc_byte_t  mdl [7];
    arc_byte_t  expQ [$];
    arc_byte_t  expV;
    logic       rdLag;
    int         failures;
    int         checks;
    int         cycles;
    analog_route_control_regs dut (.mclk(mclk), .reset(reset), .clkEn(clkEn),
        .chip_powerdown_pin_n(chip_powerdown_pin_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .hpRouteEn(),
        .pairAvgToPhones(), .diffInToPhonesEn(), .hp_attenuation_level(), .hp_silence(),
        .hp_weak_pulldown_sel(), .lineRouteEn(), .pairAvgToLine(), .diff_in_to_line_en(),
        .monoRouteEn(), .diffInToSingleOutEn(), .mono_attenuation_level(), .mono_silence(),
        .mono_dac_gain_sel(), .mono_stage_power_on());
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic close_out;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // One bus cycle; every signal changes once, right after the edge.
    task automatic op(logic w, logic r, logic [7:0] a, arc_byte_t d);
        regWrStb <= w;
        regRdStb <= r;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
    endtask : op
    task automatic knob(logic ce, logic pd);
        clkEn <= ce;
        chip_powerdown_pin_n <= pd;
        if (!pd) mdl = RST;
        op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask : knob
    task automatic wr(logic [7:0] a, arc_byte_t d);
        if (clkEn && chip_powerdown_pin_n && a >= 8'h0d && a <= 8'h13)
            mdl[a - 8'h0d] = d & MSK[a - 8'h0d];
        op(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(logic [7:0] a);
        expQ.push_back((a >= 8'h0d && a <= 8'h13) ? mdl[a - 8'h0d] : 8'h00);
        op(1'b0, 1'b1, a, arc_byte_t'($urandom));
    endtask : rd
    task automatic rdAll;
        for (int i = 8'h0c; i <= 8'h14; i++) rd(8'(i));
    endtask : rdAll
    always @(posedge mclk) rdLag <= regRdStb & clkEn & ~reset;
    // Read data stand only in the cycle after the strobe, so they are judged there.
    always @(negedge mclk) begin
        if (rdLag === 1'b1 && expQ.size() > 0) begin
            expV = expQ.pop_front();
            `CMP(regRdData, expV)
        end
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        reset = 1'b1;
        clkEn = 1'b1;
        chip_powerdown_pin_n = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        failures = 0;
        checks = 0;
        cycles = 0;
        mdl = RST;
        void'($urandom(32'hfe1a5f57));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rdAll();
        $display("test reset values done");
        for (int i = 0; i < 7; i++) begin
            wr(8'h0d + 8'(i), 8'hff);
            rd(8'h0d + 8'(i));
        end
        wr(8'h0e, 8'h3f);
        wr(8'h13, 8'h1f);
        wr(8'h11, 8'h06);
        rdAll();
        $display("test masks and gating done");
        knob(1'b1, 1'b0);
        wr(8'h0f, 8'h5a);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        knob(1'b1, 1'b1);
        rdAll();
        $display("test power-down done");
        knob(1'b0, 1'b1);
        wr(8'h12, 8'ha5);
        knob(1'b1, 1'b1);
        rd(8'h12);
        $display("test clock enable done");
        repeat (80) begin
            if ($urandom_range(1) == 1) wr(8'h0b + 8'($urandom_range(10)), arc_byte_t'($urandom));
            else rd(8'h0b + 8'($urandom_range(10)));
        end
        rdAll();
        op(1'b0, 1'b0, 8'h00, 8'h00);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        $display("test random traffic done");
        close_out();
    end
endmodule : analog_route_control_regs_tb
